// File: status_pin_pkg.sv
// Package of constants and carrier types for the status and control pin logic
// ------------------------------------------------------------------
// Notes on behaviour
// [R01] No pending status: answer interrupt request NAK
// [R02] Pending status: return exactly two bytes
// [R03] Byte0 gpio bits, byte1 speed and power
// [R04] Non-input gpio reported as zero
// [R05] Gpio direction/default loaded from config bytes
// [R06] Host may rewrite gpio settings at run time
// [R07] System must hold request low for buttons
// [R08] Media input honoured only when enabled
// [R09] Config bit 1 picks media input polarity
// [R10] No media: sense 0x3a, qualifier 0x00
// [R11] Media returns: report 0x28 once at query
// [R12] Removable is master, fixed drive slave
// [R13] Drive scan skipped when scan bit clear
// [R14] Low power pin: zero awake, released suspended
// [R15] Vbus loss plus bit 4 floats ata pins
// [R16] Sample vbus gate at start, every 20 ms
// [R17] Ata pullup: zero idle, one active, floats
// [R18] Pullup and budget pins may become inputs
// [R19] Budget asserted normally, dropped in low power
// [R20] Small package: budget only when bus powered
// [R21] Power select taken only at reset
// [R22] Serial port busy at startup for config
// [R23] Power select one: 0xfa bus, zero: 0x01 self
// [R24] Pull-up needs vbus and media enable or drive
// [R25] Cfg bit 7: pullup pin read as gpio2
// [R26] Latch pending on request, clear when delivered
// ------------------------------------------------------------------
package status_pin_pkg;
  // Register offsets of the command port
  localparam logic [3:0] OFF_CFG08 = 4'h0;
  localparam logic [3:0] OFF_GPIO_DIR = 4'h1;
  localparam logic [3:0] OFF_GPIO_OUT = 4'h2;
  localparam logic [3:0] OFF_CTRL = 4'h3;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_SENSE = 4'h5;
  localparam logic [3:0] OFF_DESC = 4'h6;
  localparam logic [3:0] OFF_SENSE_ACK = 4'h7;
  // Config byte 0x08 field positions
  localparam int CFG_MEDIA_EN = 0;
  localparam int CFG_MEDIA_POL = 1;
  localparam int CFG_ATA_TRI = 4;
  localparam int CFG_DRIVE_SCAN = 6;
  localparam int CFG_PUEN_GPIO = 7;
  // Control register field positions
  localparam int CTL_SUSPEND = 0;
  localparam int CTL_ATA_ACTIVE = 1;
  localparam int CTL_DRIVE_FOUND = 2;
  localparam int CTL_HIGH_SPEED = 3;
  localparam int CTL_SMALL_PKG = 4;
  localparam int CTL_BUDGET_GPIO = 5;
  localparam int CTL_CFG_LOAD = 6;
  // Reset values
  localparam logic [7:0] CFG08_RST = 8'h00;
  localparam logic [7:0] GPIO_DIR_RST = 8'h00;
  localparam logic [7:0] GPIO_OUT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Status word layout
  localparam int GPIO_W = 6;
  localparam int SW_BUS_PWR = 8;
  localparam int SW_HIGH_SPEED = 9;
  // Sense codes
  localparam logic [7:0] ASC_NO_MEDIA = 8'h3a;
  localparam logic [7:0] ASC_CHANGED = 8'h28;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASQ_ZERO = 8'h00;
  // Descriptor power values
  localparam logic [7:0] MAXPWR_BUS = 8'hfa;
  localparam logic [7:0] MAXPWR_SELF = 8'h01;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int VBUS_POLL_MS = 20;
  localparam int VBUS_POLL_CYC = VBUS_POLL_MS * 1000 * CLK_MHZ;
  localparam int EEPROM_MS = 5;
  localparam int EEPROM_CYC = EEPROM_MS * 1000 * CLK_MHZ;
  localparam int SCL_HALF_CYC = 1250;

  typedef struct packed {
    logic [5:0] reserved_hi;
    logic high_speed;
    logic bus_powered;
    logic [1:0] reserved_lo;
    logic [5:0] gpio;
  } status_word_t;

  typedef struct packed {
    logic [7:0] asc;
    logic [7:0] asq;
  } sense_t;

  typedef enum logic [2:0] {
    EP_IDLE = 3'b001,
    EP_BYTE0 = 3'b010,
    EP_BYTE1 = 3'b100
  } ep_state_t;
endpackage

// File: status_pin_logic.sv
// Status word assembly and system control pin logic of the bridge
`timescale 1ns/1ps
module status_pin_logic #(
  parameter int VBUS_POLL_CYCLES = status_pin_pkg::VBUS_POLL_CYC,
  parameter int EEPROM_CYCLES = status_pin_pkg::EEPROM_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Interrupt endpoint towards the USB engine
  input wire logic ep_req_i,
  output logic ep_nak_o,
  output logic ep_valid_o,
  output logic [7:0] ep_data_o,
  output logic ep_last_o,
  // System pins
  input wire logic system_interrupt_request_i,
  input wire logic media_present_input_i,
  input wire logic vbus_present_gate_i,
  input wire logic power_source_select_i,
  input wire logic [5:0] gpio_in_i,
  output logic [5:0] gpio_out_o,
  output logic [5:0] gpio_oe_o,
  output logic low_power_indicator_n_o,
  output logic low_power_indicator_n_oe_o,
  input wire logic ata_pullup_enable_i,
  output logic ata_pullup_enable_o,
  output logic ata_pullup_enable_oe_o,
  input wire logic current_budget_n_i,
  output logic current_budget_n_o,
  output logic current_budget_n_oe_o,
  output logic ata_drive_oe_o,
  output logic dplus_pullup_o,
  output logic startup_drive_scan_o,
  output logic eeprom_scl_o,
  output logic eeprom_scl_oe_o,
  output logic [7:0] max_power_o,
  output logic self_powered_o
);
  import status_pin_pkg::*;

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  logic [7:0] cfg08_q;
  logic [7:0] gpio_dir_q;
  logic [7:0] gpio_out_q;
  logic [7:0] ctrl_q;
  logic ep_sent;
  logic sense_ack;
  ep_state_t ep_q;

  // Byte 0x08 image and gpio settings; written at load time and by the host later
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg08_q <= CFG08_RST;
      gpio_dir_q <= GPIO_DIR_RST;
      gpio_out_q <= GPIO_OUT_RST;
      ctrl_q <= CTRL_RST;
    end
    else if (wr_i)
    begin
      case (addr_i)
        OFF_CFG08: cfg08_q <= wdata_i[7:0];
        OFF_GPIO_DIR: gpio_dir_q <= wdata_i[7:0]; // [R05] [R06]
        OFF_GPIO_OUT: gpio_out_q <= wdata_i[7:0]; // [R05] [R06]
        OFF_CTRL: ctrl_q <= wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Direction bit one marks an input; outputs drive default levels
  always_comb
  begin
    gpio_oe_o = ~gpio_dir_q[5:0];
    gpio_out_o = gpio_out_q[5:0];
  end

  // ------------------------------------------------------------------
  // Power source, latched once on leaving reset
  // ------------------------------------------------------------------
  logic pwr_taken_q;
  logic bus_pwr_q;

  // Strap caught on the first clock after release, never under reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwr_taken_q <= 1'b0;
    else
      pwr_taken_q <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_i && !pwr_taken_q)
      bus_pwr_q <= power_source_select_i; // [R21]
  end

  // Hosts never re-poll the descriptor, so later changes are ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      max_power_o <= MAXPWR_SELF;
      self_powered_o <= 1'b1;
    end
    else if (!pwr_taken_q)
    begin
      max_power_o <= power_source_select_i ? MAXPWR_BUS : MAXPWR_SELF; // [R23]
      self_powered_o <= ~power_source_select_i; // [R23]
    end
  end

  // ------------------------------------------------------------------
  // Startup serial port activity and vbus polling
  // ------------------------------------------------------------------
  logic [31:0] boot_cnt_q;
  logic [15:0] scl_cnt_q;
  logic scl_q;
  logic booting;

  assign booting = boot_cnt_q != 32'h0;

  // Serial clock toggles during the configuration read window only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      boot_cnt_q <= 32'(EEPROM_CYCLES);
      scl_cnt_q <= 16'h0;
      scl_q <= 1'b1;
    end
    else if (booting)
    begin
      boot_cnt_q <= boot_cnt_q - 32'h1; // [R22]
      if (scl_cnt_q == 16'(SCL_HALF_CYC - 1))
      begin
        scl_cnt_q <= 16'h0;
        scl_q <= ~scl_q;
      end
      else
        scl_cnt_q <= scl_cnt_q + 16'h1;
    end
    else
      scl_q <= 1'b1;
  end

  // Open-drain: drive only a low level, pull-up makes the high
  assign eeprom_scl_o = 1'b0;
  assign eeprom_scl_oe_o = booting && !scl_q; // [R22]

  logic [31:0] poll_cnt_q;
  logic vbus_q;

  // First sample right after reset, then once per poll period
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      poll_cnt_q <= 32'h0;
      vbus_q <= 1'b0;
    end
    else if (poll_cnt_q == 32'h0)
    begin
      vbus_q <= vbus_present_gate_i; // [R16]
      poll_cnt_q <= 32'(VBUS_POLL_CYCLES - 1);
    end
    else
      poll_cnt_q <= poll_cnt_q - 32'h1;
  end

  // Pull-up waits for vbus and either media detection enabled or a fixed drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dplus_pullup_o <= 1'b0;
    else
      dplus_pullup_o <= vbus_q && !booting
        && (cfg08_q[CFG_MEDIA_EN] || ctrl_q[CTL_DRIVE_FOUND]); // [R16] [R24]
  end

  // Scan request; the drive engine treats a removable as master and fixed as slave
  assign startup_drive_scan_o = cfg08_q[CFG_DRIVE_SCAN] && !booting; // [R13] [R12]

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  logic ata_float;
  assign ata_float = !vbus_q && cfg08_q[CFG_ATA_TRI]; // [R15]
  // When not floated the ata engine drives its inactive levels
  assign ata_drive_oe_o = !ata_float; // [R15]

  assign low_power_indicator_n_o = 1'b0; // [R14]
  assign low_power_indicator_n_oe_o = !ctrl_q[CTL_SUSPEND]; // [R14]

  assign ata_pullup_enable_o = ctrl_q[CTL_ATA_ACTIVE]; // [R17]
  assign ata_pullup_enable_oe_o = !ata_float && !cfg08_q[CFG_PUEN_GPIO]; // [R17] [R18]

  // Budget pin is active low; small package shows it only when bus powered
  assign current_budget_n_o = ctrl_q[CTL_SUSPEND]; // [R19]
  assign current_budget_n_oe_o = !ctrl_q[CTL_BUDGET_GPIO]
    && (!ctrl_q[CTL_SMALL_PKG] || bus_pwr_q); // [R18] [R20]

  // ------------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------------
  status_word_t sw;
  logic [5:0] gpio_level;

  // Pullup pin replaces gpio2 when it is an input; budget pin replaces gpio1
  always_comb
  begin
    gpio_level = gpio_in_i;
    if (cfg08_q[CFG_PUEN_GPIO])
      gpio_level[2] = ata_pullup_enable_i; // [R25]
    if (ctrl_q[CTL_BUDGET_GPIO])
      gpio_level[1] = current_budget_n_i; // [R18]
    sw = '0; // [R03]
    sw.gpio = gpio_level & gpio_dir_q[5:0]; // [R04]
    sw.high_speed = ctrl_q[CTL_HIGH_SPEED]; // [R03]
    sw.bus_powered = bus_pwr_q; // [R03]
  end

  // ------------------------------------------------------------------
  // Interrupt endpoint
  // ------------------------------------------------------------------
  logic pend_q;
  logic [15:0] snap_q;

  // Request sets pending; set wins over the clear of a finished delivery
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pend_q <= 1'b0;
    else if (system_interrupt_request_i)
      pend_q <= 1'b1; // [R26]
    else if (ep_sent)
      pend_q <= 1'b0; // [R26]
  end

  assign ep_sent = ep_q == EP_BYTE1;
  assign ep_nak_o = ep_req_i && ep_q == EP_IDLE && !pend_q; // [R01]

  // Two byte payload, low byte first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ep_q <= EP_IDLE;
      snap_q <= 16'h0;
    end
    else
    begin
      case (ep_q)
        EP_IDLE:
          if (ep_req_i && pend_q)
          begin
            snap_q <= sw;
            ep_q <= EP_BYTE0; // [R02]
          end
        EP_BYTE0: ep_q <= EP_BYTE1;
        EP_BYTE1: ep_q <= EP_IDLE; // [R02]
        default: ep_q <= EP_IDLE;
      endcase
    end
  end

  always_comb
  begin
    ep_valid_o = ep_q != EP_IDLE;
    ep_last_o = ep_q == EP_BYTE1;
    ep_data_o = ep_q == EP_BYTE1 ? snap_q[15:8] : (ep_q == EP_BYTE0 ? snap_q[7:0] : 8'h00);
  end

  // ------------------------------------------------------------------
  // Removable media sense
  // ------------------------------------------------------------------
  logic media_on;
  logic changed_q;
  sense_t sense;

  // Polarity bit one means active high
  assign media_on = media_present_input_i == cfg08_q[CFG_MEDIA_POL]; // [R09]

  // Media changed flag: set on absence, cleared when the host reads it once present
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      changed_q <= 1'b0;
    else if (cfg08_q[CFG_MEDIA_EN] && !media_on)
      changed_q <= 1'b1; // [R11]
    else if (sense_ack)
      changed_q <= 1'b0; // [R11]
  end

  assign sense_ack = rd_i && addr_i == OFF_SENSE_ACK;

  always_comb
  begin
    sense.asq = ASQ_ZERO;
    if (cfg08_q[CFG_MEDIA_EN] && !media_on) // [R08]
      sense.asc = ASC_NO_MEDIA; // [R10]
    else if (changed_q)
      sense.asc = ASC_CHANGED; // [R11]
    else
      sense.asc = ASC_NONE;
  end

  // ------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 16'h0;
    else if (rd_i)
    begin
      case (addr_i)
        OFF_CFG08: rdata_o <= {8'h00, cfg08_q};
        OFF_GPIO_DIR: rdata_o <= {8'h00, gpio_dir_q};
        OFF_GPIO_OUT: rdata_o <= {8'h00, gpio_out_q};
        OFF_CTRL: rdata_o <= {8'h00, ctrl_q};
        OFF_STATUS: rdata_o <= sw;
        OFF_SENSE, OFF_SENSE_ACK: rdata_o <= sense;
        OFF_DESC: rdata_o <= {7'h00, self_powered_o, max_power_o};
        default: rdata_o <= 16'h0;
      endcase
    end
  end
endmodule // status_pin_logic

// File: status_pin_sva.sv
// Port checker of the status and control pin logic
`timescale 1ns/1ps
module status_pin_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ep_req_i,
  input wire logic ep_nak_o,
  input wire logic ep_valid_o,
  input wire logic [7:0] ep_data_o,
  input wire logic ep_last_o,
  input wire logic low_power_indicator_n_o,
  input wire logic low_power_indicator_n_oe_o,
  input wire logic ata_pullup_enable_oe_o,
  input wire logic ata_drive_oe_o,
  input wire logic dplus_pullup_o,
  input wire logic eeprom_scl_oe_o,
  input wire logic [7:0] max_power_o,
  input wire logic self_powered_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // Endpoint payload
  // ----
  property p_nak; ep_nak_o |-> ep_req_i && !ep_valid_o; endproperty
  a_nak: assert property (p_nak) else $error("refusal without request");
  property p_two; ep_valid_o && !ep_last_o |=> ep_valid_o && ep_last_o; endproperty
  a_two: assert property (p_two) else $error("second byte missing");
  property p_end; ep_last_o |-> ep_valid_o ##1 !ep_valid_o; endproperty
  a_end: assert property (p_end) else $error("payload too long");
  property p_b0; ep_valid_o && !ep_last_o |-> ep_data_o[7:6] == 2'h0; endproperty
  a_b0: assert property (p_b0) else $error("byte0 reserved set");
  // Bus powered flag must agree with the reported descriptor
  property p_b1;
    ep_last_o |-> ep_data_o[7:2] == 6'h00 && ep_data_o[0] == !self_powered_o;
  endproperty
  a_b1: assert property (p_b1) else $error("byte1 wrong");
  // ----
  // Pins
  // ----
  property p_low; low_power_indicator_n_oe_o |-> !low_power_indicator_n_o; endproperty
  a_low: assert property (p_low) else $error("low power pin high");
  property p_tri; !ata_drive_oe_o |-> !ata_pullup_enable_oe_o; endproperty
  a_tri: assert property (p_tri) else $error("pullup pin not floated");
  property p_pwr; max_power_o == (self_powered_o ? 8'h01 : 8'hfa); endproperty
  a_pwr: assert property (p_pwr) else $error("power pair wrong");
  // The strap is taken once after reset, so later changes must not show
  property p_keep; !$past(rst_i) && !$past(rst_i, 2) |-> $stable(max_power_o); endproperty
  a_keep: assert property (p_keep) else $error("power changed in run");
  property p_boot; eeprom_scl_oe_o |-> !dplus_pullup_o; endproperty
  a_boot: assert property (p_boot) else $error("pull-up during boot");
  c_pay: cover property (ep_valid_o && ep_last_o);
  c_nak: cover property (ep_nak_o);
  c_dp: cover property ($rose(dplus_pullup_o));
endmodule // status_pin_sva

bind status_pin_logic status_pin_sva chk_u (.clk_i, .rst_i, .ep_req_i, .ep_nak_o,
  .ep_valid_o, .ep_data_o, .ep_last_o, .low_power_indicator_n_o, .low_power_indicator_n_oe_o,
  .ata_pullup_enable_oe_o, .ata_drive_oe_o, .dplus_pullup_o, .eeprom_scl_oe_o,
  .max_power_o, .self_powered_o);

// File: usb_ep_model.sv
// Model of the USB engine polling the interrupt endpoint
`timescale 1ns/1ps
module usb_ep_model (
  input wire logic clk_i,
  input wire logic ep_nak_o,
  input wire logic ep_valid_o,
  input wire logic [7:0] ep_data_o,
  input wire logic ep_last_o,
  output logic ep_req_o
);
  initial ep_req_o = 1'b0;
  // One poll: a refusal, or two bytes; a hang leaves unknowns behind
  task automatic poll(output logic nak, output logic [15:0] word);
    word = 16'hxxxx;
    @(posedge clk_i);
    ep_req_o <= 1'b1;
    #1;
    nak = ep_nak_o;
    @(posedge clk_i);
    ep_req_o <= 1'b0;
    if (nak === 1'b0)
    begin
      repeat (4)
      begin
        #1;
        if (ep_valid_o === 1'b1 && ep_last_o === 1'b0)
          word[7:0] = ep_data_o;
        if (ep_valid_o === 1'b1 && ep_last_o === 1'b1)
          word[15:8] = ep_data_o;
        @(posedge clk_i);
      end
    end
  endtask
endmodule // usb_ep_model

// File: test_bridge_status_pin_logic.sv
// Self-checking testbench of the status and control pin logic
`timescale 1ns/1ps
module test_bridge_status_pin_logic;
  import status_pin_pkg::*;
  localparam int POLL = 50;
  // Boot window long enough for one full serial clock period
  localparam int EEP = 2 * SCL_HALF_CYC + 100;
  logic clk_i, rst_i, wr_i, rd_i, ep_req_i, ep_nak_o, ep_valid_o, ep_last_o, nak;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata_o, w;
  logic [7:0] ep_data_o, max_power_o;
  logic [5:0] gpio_in_i, gpio_out_o, gpio_oe_o;
  logic system_interrupt_request_i, media_present_input_i, vbus_present_gate_i;
  logic power_source_select_i, low_power_indicator_n_o, low_power_indicator_n_oe_o;
  logic ata_pullup_enable_i, ata_pullup_enable_o, ata_pullup_enable_oe_o;
  logic current_budget_n_i, current_budget_n_o, current_budget_n_oe_o, self_powered_o;
  logic ata_drive_oe_o, dplus_pullup_o, startup_drive_scan_o, eeprom_scl_o, eeprom_scl_oe_o;
  int err_total, num_checks;
  // Short poll and boot counts keep the run brief
  status_pin_logic #(.VBUS_POLL_CYCLES(POLL), .EEPROM_CYCLES(EEP)) dut_u (.clk_i, .rst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ep_req_i, .ep_nak_o, .ep_valid_o,
    .ep_data_o, .ep_last_o, .system_interrupt_request_i, .media_present_input_i,
    .vbus_present_gate_i, .power_source_select_i, .gpio_in_i, .gpio_out_o, .gpio_oe_o,
    .low_power_indicator_n_o, .low_power_indicator_n_oe_o, .ata_pullup_enable_i,
    .ata_pullup_enable_o, .ata_pullup_enable_oe_o, .current_budget_n_i,
    .current_budget_n_o, .current_budget_n_oe_o, .ata_drive_oe_o, .dplus_pullup_o,
    .startup_drive_scan_o, .eeprom_scl_o, .eeprom_scl_oe_o, .max_power_o, .self_powered_o);
  usb_ep_model host_u (.clk_i, .ep_nak_o, .ep_valid_o, .ep_data_o, .ep_last_o,
    .ep_req_o(ep_req_i));
  // ----
  // Helpers
  // ----
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Serial clock is pulled low for one half period, then released
  task automatic boot_wait();
    int n;
    n = 0;
    repeat (EEP + 4)
    begin
      @(posedge clk_i);
      #1;
      if (eeprom_scl_oe_o === 1'b1)
        n++;
    end
    chk("scl low", 16'(SCL_HALF_CYC), 16'(n));
    chk("scl freed", 16'h0, {15'h0, eeprom_scl_oe_o});
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    boot_wait();
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rdc(input string s, input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(s, e, rdata_o);
  endtask
  task automatic irq();
    @(posedge clk_i);
    system_interrupt_request_i <= 1'b1;
    @(posedge clk_i);
    system_interrupt_request_i <= 1'b0;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_boot();
    host_u.poll(nak, w);
    chk("idle nak", 16'h1, {15'h0, nak});
    rdc("desc", OFF_DESC, 16'h00fa);
    rdc("unmapped", 4'hf, 16'h0);
    @(posedge clk_i);
    power_source_select_i <= 1'b0;
    rdc("desc kept", OFF_DESC, 16'h00fa);
    do_reset();
    rdc("desc self", OFF_DESC, 16'h0101);
    wr(OFF_CTRL, 16'h0010);
    chk("budget self", 16'h0, {15'h0, current_budget_n_oe_o});
    power_source_select_i <= 1'b1;
    do_reset();
  endtask
  task automatic s_status();
    wr(OFF_GPIO_DIR, 16'h002d);
    wr(OFF_GPIO_OUT, 16'h0015);
    wr(OFF_CTRL, 16'h0008);
    gpio_in_i <= 6'h3f;
    chk("gpio pins", 16'h1215, {2'h0, gpio_oe_o, 2'h0, gpio_out_o});
    irq();
    host_u.poll(nak, w);
    chk("payload", 16'h032d, w);
    rdc("status", OFF_STATUS, 16'h032d);
    host_u.poll(nak, w);
    chk("nak after", 16'h1, {15'h0, nak});
    wr(OFF_CFG08, 16'h0080);
    ata_pullup_enable_i <= 1'b1;
    gpio_in_i <= 6'h00;
    irq();
    host_u.poll(nak, w);
    chk("pullup gpio", 16'h0304, w);
    chk("pullup oe", 16'h0, {15'h0, ata_pullup_enable_oe_o});
  endtask
  task automatic s_media();
    wr(OFF_CFG08, 16'h0003);
    rdc("no media", OFF_SENSE, {ASC_NO_MEDIA, ASQ_ZERO});
    @(posedge clk_i);
    media_present_input_i <= 1'b1;
    idle(2);
    rdc("changed", OFF_SENSE_ACK, {ASC_CHANGED, ASQ_ZERO});
    rdc("after ack", OFF_SENSE, 16'h0000);
    wr(OFF_CFG08, 16'h0001);
    rdc("low active", OFF_SENSE, {ASC_NO_MEDIA, ASQ_ZERO});
  endtask
  task automatic s_pins();
    wr(OFF_CFG08, 16'h0011);
    vbus_present_gate_i <= 1'b0;
    idle(POLL + 4);
    chk("vbus lost", 16'h0, {13'h0, ata_drive_oe_o, dplus_pullup_o,
      ata_pullup_enable_oe_o});
    wr(OFF_CFG08, 16'h0001);
    vbus_present_gate_i <= 1'b1;
    idle(POLL + 4);
    chk("vbus back", 16'h3, {14'h0, ata_drive_oe_o, dplus_pullup_o});
    wr(OFF_CTRL, 16'h0002);
    chk("pullup act", 16'h3, {14'h0, ata_pullup_enable_o, ata_pullup_enable_oe_o});
    wr(OFF_CTRL, 16'h0000);
    chk("pullup idle", 16'h0, {15'h0, ata_pullup_enable_o});
    wr(OFF_CFG08, 16'h0040);
    chk("scan on", 16'h1, {15'h0, startup_drive_scan_o});
    idle(POLL + 4);
    chk("no enable", 16'h0, {15'h0, dplus_pullup_o});
    wr(OFF_CTRL, 16'h0004);
    idle(POLL + 4);
    chk("drive found", 16'h1, {15'h0, dplus_pullup_o});
    wr(OFF_CFG08, 16'h0000);
    chk("scan off", 16'h0, {15'h0, startup_drive_scan_o});
  endtask
  task automatic s_power();
    wr(OFF_CTRL, 16'h0001);
    chk("suspend", 16'h1, {14'h0, low_power_indicator_n_oe_o, current_budget_n_o});
    wr(OFF_CTRL, 16'h0010);
    chk("awake", 16'h5, {13'h0, low_power_indicator_n_oe_o, current_budget_n_o,
      current_budget_n_oe_o});
    wr(OFF_CTRL, 16'h0020);
    chk("budget in", 16'h0, {15'h0, current_budget_n_oe_o});
  endtask
  initial
  begin
    {wr_i, rd_i, system_interrupt_request_i, media_present_input_i} = 4'h0;
    {addr_i, wdata_i, gpio_in_i, ata_pullup_enable_i} = 27'h0;
    {rst_i, vbus_present_gate_i, power_source_select_i, current_budget_n_i} = 4'hf;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    boot_wait();
    s_boot();
    s_status();
    s_media();
    s_pins();
    s_power();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end
endmodule // test_bridge_status_pin_logic
